// *** core/prom_readout_pkg.sv ***
// Shared constants and carrier types for the configuration memory read-out port
package prom_readout_pkg;

    localparam int BYTE_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int MEM_BYTES = 4096;
    localparam int COUNT_WIDTH = 26;
    localparam int TERMINAL_COUNT = 32767;

    // System clock and the fastest configuration clock the port accepts
    localparam int SYS_CLOCK_KHZ = 125000;
    localparam int MAX_CONFIG_CLOCK_KHZ = 33000;
    // Shortest allowed edge spacing rounds down, never below one cycle
    localparam int MIN_EDGE_CYCLES_RAW = SYS_CLOCK_KHZ / MAX_CONFIG_CLOCK_KHZ;
    localparam int MIN_EDGE_CYCLES = (MIN_EDGE_CYCLES_RAW < 1) ? 1 : MIN_EDGE_CYCLES_RAW;
    localparam int SPACING_WIDTH = 4;

    // Boundary-scan chain layout
    localparam int SCAN_LENGTH = 25;
    localparam int SCAN_CLOCK_IN = 0;
    localparam int SCAN_CASCADE_OE = 11;
    localparam int SCAN_CASCADE_OUT = 12;
    localparam int SCAN_CE_IN = 15;
    localparam int SCAN_OER_OE = 18;
    localparam int SCAN_OER_OUT = 19;
    localparam int SCAN_OER_IN = 20;
    localparam int SCAN_DATA_OUT_POS [BYTE_WIDTH] = '{4, 6, 2, 8, 24, 10, 17, 14};
    localparam int SCAN_DATA_OE_POS [BYTE_WIDTH] = '{3, 5, 1, 7, 23, 9, 16, 13};

    localparam logic [BYTE_WIDTH-1:0] DATA_ALL_OFF = 8'hFF;
    localparam logic [BYTE_WIDTH-1:0] DATA_SERIAL_ON = 8'hFE;

    typedef struct packed {
        logic [BYTE_WIDTH-1:0] value;
        logic [BYTE_WIDTH-1:0] oe_n;
    } data_pins_type;

    typedef struct packed {
        logic passed_terminal;
        logic underrun;
        logic overspeed;
    } port_status_type;

    typedef enum logic [3:0] {
        FETCH_HOLD = 4'b0001,
        FETCH_READ = 4'b0010,
        FETCH_OFFER = 4'b0100,
        FETCH_DONE = 4'b1000
    } fetch_state_type;

endpackage : prom_readout_pkg

// *** core/byte_stream_fifo.sv ***
// Synchronous FIFO with flush, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] write_ptr;
    logic [AW:0] read_ptr;
    logic [AW:0] next_write_ptr;
    logic [AW:0] next_read_ptr;
    logic push;
    logic pop;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign empty = (write_ptr == read_ptr);
    assign full = (write_ptr[AW] != read_ptr[AW]) && (write_ptr[AW-1:0] == read_ptr[AW-1:0]);
    assign in_ready = !full && !flush;
    assign out_valid = !empty && !flush;
    assign out_data = store[read_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_write_ptr = write_ptr;
        next_read_ptr = read_ptr;
        if (flush) begin
            next_write_ptr = '0;
            next_read_ptr = '0;
        end else begin
            if (push) begin
                next_write_ptr = write_ptr + 1'b1;
            end
            if (pop) begin
                next_read_ptr = read_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            write_ptr <= '0;
            read_ptr <= '0;
        end else begin
            write_ptr <= next_write_ptr;
            read_ptr <= next_read_ptr;
        end
    end

    // Storage has no reset; emptiness guards every read
    always_ff @(posedge clock) begin
        if (push) begin
            store[write_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : byte_stream_fifo
`default_nettype wire

// *** core/config_prom_readout_port.sv ***
// Read-out port of a cascadable configuration memory: serial and byte-wide streaming
// Functional notes
// - Serial mode drives data on serial pin
// - Parallel mode presents byte per clock edge
// - Free-running clock tolerated, no length count
// - Unselected device keeps data outputs released
// - Scan cells per data pin, fixed positions
// - Configuration clock up to 33 MHz
// - Count edges only when enabled, not reset
// - Reset pin low: clear, release; pin pulled low only in reset
// - Chip enable high: standby, clear, release
// - Cascade low after terminal count passed
`timescale 1ns/1ps
`default_nettype none
module config_prom_readout_port #(
    parameter int MEM_BYTES = prom_readout_pkg::MEM_BYTES,
    parameter int COUNT_WIDTH = prom_readout_pkg::COUNT_WIDTH,
    parameter int TERMINAL_COUNT = prom_readout_pkg::TERMINAL_COUNT,
    parameter int FIFO_DEPTH = prom_readout_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic config_clock,
    input wire logic chip_enable_n,
    input wire logic output_enable_reset_n_in,
    output logic output_enable_reset_n_out,
    output logic output_enable_reset_n_oe_n,
    input wire logic parallel_mode,
    input wire logic load_write,
    input wire logic [$clog2(prom_readout_pkg::MEM_BYTES)-1:0] load_address,
    input wire logic [prom_readout_pkg::BYTE_WIDTH-1:0] load_data,
    output prom_readout_pkg::data_pins_type data_pins,
    output logic cascade_enable_out_n,
    output logic cascade_enable_out_oe_n,
    output prom_readout_pkg::port_status_type status,
    output logic [prom_readout_pkg::SCAN_LENGTH-1:0] boundary_scan_capture
);
    import prom_readout_pkg::*;

    localparam int AW = $clog2(MEM_BYTES);
    localparam logic [AW-1:0] LAST_ADDRESS = AW'(MEM_BYTES - 1);
    // Cascade trips on the first edge taken once the count reaches this
    localparam logic [COUNT_WIDTH-1:0] TERMINAL_LIMIT = COUNT_WIDTH'(TERMINAL_COUNT);
    // Fewest system cycles between two edges before overspeed is flagged
    localparam logic [SPACING_WIDTH-1:0] EDGE_SPACING = SPACING_WIDTH'(MIN_EDGE_CYCLES);

    // Storage has no reset; load it before the first enable
    logic [BYTE_WIDTH-1:0] memory [MEM_BYTES];

    // Port selected: chip enable low and reset pin high
    logic active;
    logic clock_previous;
    logic clock_edge;
    logic advance;

    fetch_state_type fetch_state;
    fetch_state_type next_fetch_state;
    logic [AW-1:0] fetch_address;
    logic [AW-1:0] next_fetch_address;
    logic [BYTE_WIDTH-1:0] fetch_word;
    logic [BYTE_WIDTH-1:0] next_fetch_word;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [BYTE_WIDTH-1:0] fifo_out_data;

    logic [BYTE_WIDTH-1:0] shift_byte;
    logic [BYTE_WIDTH-1:0] next_shift_byte;
    logic [2:0] bit_index;
    logic [2:0] next_bit_index;
    logic holding;
    logic next_holding;
    logic byte_done;

    logic [COUNT_WIDTH-1:0] edge_count;
    logic [COUNT_WIDTH-1:0] next_edge_count;
    port_status_type next_status;
    logic [SPACING_WIDTH-1:0] spacing;
    logic [SPACING_WIDTH-1:0] next_spacing;

    data_pins_type next_data_pins;
    logic next_cascade_n;
    logic [SCAN_LENGTH-1:0] next_scan;

    assign active = !chip_enable_n && output_enable_reset_n_in;
    assign clock_edge = config_clock && !clock_previous;
    // Only edges of a selected device move the stream; others are ignored
    assign advance = clock_edge && active && holding;

    // Open-drain reset pin: only ever pulled low, and only while held in reset
    assign output_enable_reset_n_out = 1'b0;
    assign output_enable_reset_n_oe_n = reset_n;
    // Cascade output is always driven so the next chip never floats
    assign cascade_enable_out_oe_n = 1'b0;

    // Prefetch from storage into the FIFO; a full FIFO stalls this engine
    always_comb begin
        next_fetch_state = fetch_state;
        next_fetch_address = fetch_address;
        next_fetch_word = fetch_word;
        fifo_in_valid = 1'b0;
        if (!active) begin
            next_fetch_state = FETCH_HOLD;
            next_fetch_address = '0;
        end else begin
            case (fetch_state)
                FETCH_HOLD: begin
                    next_fetch_state = FETCH_READ;
                end
                FETCH_READ: begin
                    next_fetch_word = memory[fetch_address];
                    next_fetch_state = FETCH_OFFER;
                end
                FETCH_OFFER: begin
                    fifo_in_valid = 1'b1;
                    if (fifo_in_ready) begin
                        if (fetch_address == LAST_ADDRESS) begin
                            next_fetch_state = FETCH_DONE;
                        end else begin
                            next_fetch_address = fetch_address + 1'b1;
                            next_fetch_state = FETCH_READ;
                        end
                    end
                end
                FETCH_DONE: begin
                    next_fetch_state = FETCH_DONE;
                end
                default: begin
                    next_fetch_state = FETCH_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fetch_state <= FETCH_HOLD;
            fetch_address <= '0;
            fetch_word <= '0;
        end else begin
            fetch_state <= next_fetch_state;
            fetch_address <= next_fetch_address;
            fetch_word <= next_fetch_word;
        end
    end

    // Programming path writes storage; it never touches the stream state
    always_ff @(posedge clock) begin
        if (load_write) begin
            memory[load_address[AW-1:0]] <= load_data;
        end
    end

    byte_stream_fifo #(
        .WIDTH(BYTE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) byte_stream_fifo_inst (
        .clock(clock),
        .reset_n(reset_n),
        .flush(!active),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fetch_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // A serial byte lasts eight edges, a parallel byte one
    assign byte_done = parallel_mode || (bit_index == 3'd7);
    assign fifo_out_ready = active && (!holding || (advance && byte_done));

    // Output stage: bit 7 of the shift byte is the serial pin
    always_comb begin
        next_shift_byte = shift_byte;
        next_bit_index = bit_index;
        next_holding = holding;
        if (!active) begin
            next_holding = 1'b0;
            next_bit_index = '0;
        end else if (fifo_out_ready) begin
            next_holding = fifo_out_valid;
            next_bit_index = '0;
            if (fifo_out_valid) begin
                next_shift_byte = fifo_out_data;
            end
        end else if (advance) begin
            next_shift_byte = {shift_byte[BYTE_WIDTH-2:0], 1'b0};
            next_bit_index = bit_index + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            shift_byte <= '0;
            bit_index <= '0;
            holding <= 1'b0;
        end else begin
            shift_byte <= next_shift_byte;
            bit_index <= next_bit_index;
            holding <= next_holding;
        end
    end

    // Pins, counter, cascade output and status
    always_comb begin
        // Serial drives bit 0 only; the upper pins stay released
        next_data_pins.value = next_shift_byte;
        next_data_pins.oe_n = DATA_ALL_OFF;
        if (active && next_holding) begin
            next_data_pins.oe_n = parallel_mode ? '0 : DATA_SERIAL_ON;
            if (!parallel_mode) begin
                next_data_pins.value = {7'h00, next_shift_byte[BYTE_WIDTH-1]};
            end
        end
        next_edge_count = edge_count;
        next_cascade_n = cascade_enable_out_n;
        next_status = status;
        next_spacing = spacing;
        // Saturates so a long idle never looks like a fast clock
        if (spacing != '1) begin
            next_spacing = spacing + 1'b1;
        end
        if (!active) begin
            next_edge_count = '0;
            next_cascade_n = 1'b1;
            next_status.passed_terminal = 1'b0;
        end else if (clock_edge) begin
            // Counter saturates so a free-running clock never wraps it
            if (edge_count != '1) begin
                next_edge_count = edge_count + 1'b1;
            end
            if (edge_count >= TERMINAL_LIMIT) begin
                next_cascade_n = 1'b0;
                next_status.passed_terminal = 1'b1;
            end
            // Target outran the prefetch before its count was reached
            if (!holding && edge_count < TERMINAL_LIMIT) begin
                next_status.underrun = 1'b1;
            end
        end
        if (clock_edge) begin
            next_spacing = '0;
            if (spacing < EDGE_SPACING - 1'b1) begin
                next_status.overspeed = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            clock_previous <= 1'b0;
            data_pins <= '{value: '0, oe_n: DATA_ALL_OFF};
            edge_count <= '0;
            cascade_enable_out_n <= 1'b1;
            status <= '0;
            spacing <= '1;
        end else begin
            clock_previous <= config_clock;
            data_pins <= next_data_pins;
            edge_count <= next_edge_count;
            cascade_enable_out_n <= next_cascade_n;
            status <= next_status;
            spacing <= next_spacing;
        end
    end

    // Boundary-scan capture of every pin and its enable
    always_comb begin
        next_scan = '0;
        next_scan[SCAN_CLOCK_IN] = config_clock;
        next_scan[SCAN_CASCADE_OE] = cascade_enable_out_oe_n;
        next_scan[SCAN_CASCADE_OUT] = cascade_enable_out_n;
        next_scan[SCAN_CE_IN] = chip_enable_n;
        next_scan[SCAN_OER_OE] = output_enable_reset_n_oe_n;
        next_scan[SCAN_OER_OUT] = output_enable_reset_n_out;
        next_scan[SCAN_OER_IN] = output_enable_reset_n_in;
        for (int i = 0; i < BYTE_WIDTH; i++) begin
            next_scan[SCAN_DATA_OUT_POS[i]] = data_pins.value[i];
            next_scan[SCAN_DATA_OE_POS[i]] = data_pins.oe_n[i];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            boundary_scan_capture <= '0;
        end else begin
            boundary_scan_capture <= next_scan;
        end
    end
endmodule : config_prom_readout_port
`default_nettype wire

// *** tb/config_prom_readout_port_asserts.sv ***
// Concurrent checks on the pins of the configuration memory read-out port
`timescale 1ns/1ps
`default_nettype none
module config_prom_readout_port_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic config_clock,
    input wire logic chip_enable_n,
    input wire logic output_enable_reset_n_in,
    input wire logic output_enable_reset_n_out,
    input wire logic output_enable_reset_n_oe_n,
    input wire logic parallel_mode,
    input wire logic load_write,
    input wire logic [$clog2(prom_readout_pkg::MEM_BYTES)-1:0] load_address,
    input wire logic [prom_readout_pkg::BYTE_WIDTH-1:0] load_data,
    input wire prom_readout_pkg::data_pins_type data_pins,
    input wire logic cascade_enable_out_n,
    input wire logic cascade_enable_out_oe_n,
    input wire prom_readout_pkg::port_status_type status,
    input wire logic [prom_readout_pkg::SCAN_LENGTH-1:0] boundary_scan_capture
);
    import prom_readout_pkg::*;
    wire logic active = !chip_enable_n && output_enable_reset_n_in;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_reset_release;
        !output_enable_reset_n_in |=> data_pins.oe_n == 8'hFF && cascade_enable_out_n;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("pins not released");
    property p_standby;
        chip_enable_n [*2] |-> data_pins.oe_n == 8'hFF && cascade_enable_out_n;
    endproperty
    a_standby: assert property (p_standby) else $error("standby pins not released");
    property p_pin_pull;
        output_enable_reset_n_oe_n && !output_enable_reset_n_out;
    endproperty
    a_pin_pull: assert property (p_pin_pull) else $error("reset pin pulled out of reset");
    property p_terminal_flag;
        status.passed_terminal == !cascade_enable_out_n;
    endproperty
    a_terminal_flag: assert property (p_terminal_flag) else $error("terminal flag off");
    property p_cascade_cause;
        $fell(cascade_enable_out_n) |-> $past(active) && $past(config_clock)
            && !$past(config_clock, 2);
    endproperty
    a_cascade_cause: assert property (p_cascade_cause) else $error("cascade uncaused");
    property p_data_after_edge;
        $changed(data_pins.value) && !data_pins.oe_n[0] && !$past(data_pins.oe_n[0])
            |-> $past(config_clock) && !$past(config_clock, 2);
    endproperty
    a_data_after_edge: assert property (p_data_after_edge) else $error("data off edge");
    property p_serial_one_pin;
        !parallel_mode && !$past(parallel_mode) |-> data_pins.oe_n[7:1] == 7'h7F;
    endproperty
    a_serial_one_pin: assert property (p_serial_one_pin) else $error("upper pins on");
    property p_start_latency;
        $rose(active) |-> ##[2:6] !data_pins.oe_n[0];
    endproperty
    a_start_latency: assert property (p_start_latency) else $error("late first data");
endmodule : config_prom_readout_port_asserts
bind config_prom_readout_port config_prom_readout_port_asserts
    config_prom_readout_port_asserts_inst (
    .clock, .reset_n, .config_clock, .chip_enable_n, .output_enable_reset_n_in,
    .output_enable_reset_n_out, .output_enable_reset_n_oe_n, .parallel_mode, .load_write,
    .load_address, .load_data, .data_pins, .cascade_enable_out_n, .cascade_enable_out_oe_n,
    .status, .boundary_scan_capture);
`default_nettype wire

// *** tb/config_target_model.sv ***
// Target configuration logic and clock source facing the read-out port
`timescale 1ns/1ps
`default_nettype none
module config_target_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run,
    input wire logic free_run,
    input wire logic [15:0] pulse_limit,
    input wire logic [3:0] half_cycles,
    input wire prom_readout_pkg::data_pins_type data_pins,
    output logic config_clock,
    output logic cap_valid,
    output logic [7:0] cap_data
);
    import prom_readout_pkg::*;
    logic [3:0] phase;
    logic [15:0] pulses;
    logic [7:0] held;
    // Released bits read as the inverse of their last level, never a kind guess
    wire logic [7:0] line = (data_pins.value & ~data_pins.oe_n) | (~held & data_pins.oe_n);
    always_ff @(posedge clock) begin
        held <= reset_n ? (data_pins.value & ~data_pins.oe_n) | (held & data_pins.oe_n) : 8'h00;
        cap_valid <= 1'b0;
        if (!reset_n || !run) begin
            config_clock <= 1'b0;
            phase <= 4'h0;
            pulses <= 16'h0000;
        end else if (free_run || pulses < pulse_limit) begin
            if (phase + 4'h1 >= half_cycles) begin
                phase <= 4'h0;
                config_clock <= !config_clock;
                if (!config_clock) begin
                    pulses <= pulses + 16'h0001;
                    cap_valid <= 1'b1;
                    cap_data <= line;
                end
            end else begin
                phase <= phase + 4'h1;
            end
        end else begin
            config_clock <= 1'b0;
        end
    end
endmodule : config_target_model
`default_nettype wire

// *** tb/tb_config_prom_readout_port.sv ***
// Self-checking bench for the configuration memory read-out port
`timescale 1ns/1ps
`default_nettype none
module tb_config_prom_readout_port;
    import prom_readout_pkg::*;
    localparam int NBYTES = 16;
    localparam int TERM_COUNT = 20;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic chip_enable_n = 1'b1;
    logic oe_drive = 1'b1;
    logic parallel_mode = 1'b0;
    logic load_write = 1'b0;
    logic [11:0] load_address = 12'h000;
    logic [7:0] load_data = 8'h00;
    logic run = 1'b0;
    logic free_run = 1'b0;
    logic [15:0] pulse_limit = 16'h0000;
    logic [3:0] half_cycles = 4'h2;
    logic config_clock, oe_out, oe_oe_n, cascade_n, cascade_oe_n, cap_valid;
    logic [7:0] cap_data;
    logic [24:0] scan;
    data_pins_type data_pins;
    port_status_type status;
    // Open-drain pin: pull-up, bench and device may both pull it low
    wire logic oe_pin = oe_drive & (oe_oe_n | oe_out);
    int err_count = 0;
    int checks_done = 0;
    always #4 clock = ~clock;
    config_prom_readout_port #(.MEM_BYTES(NBYTES), .TERMINAL_COUNT(TERM_COUNT))
        config_prom_readout_port_inst (
        .clock, .reset_n, .config_clock, .chip_enable_n, .output_enable_reset_n_in(oe_pin),
        .output_enable_reset_n_out(oe_out), .output_enable_reset_n_oe_n(oe_oe_n),
        .parallel_mode, .load_write, .load_address, .load_data, .data_pins,
        .cascade_enable_out_n(cascade_n), .cascade_enable_out_oe_n(cascade_oe_n), .status,
        .boundary_scan_capture(scan));
    config_target_model config_target_model_inst (
        .clock, .reset_n, .run, .free_run, .pulse_limit, .half_cycles, .data_pins,
        .config_clock, .cap_valid, .cap_data);
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 29 + 90);
    endfunction : pat
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic get_cap(output logic [7:0] b);
        for (int n = 0; n < 300; n++) begin
            @(negedge clock);
            if (cap_valid === 1'b1) break;
        end
        check_bit("capture", 1'b1, cap_valid);
        b = cap_data;
    endtask : get_cap
    task automatic enable(input logic par, input logic [3:0] half);
        @(posedge clock);
        parallel_mode <= par;
        half_cycles <= half;
        chip_enable_n <= 1'b0;
        tick(10);
        @(posedge clock) run <= 1'b1;
    endtask : enable
    task automatic stop();
        @(posedge clock);
        run <= 1'b0;
        chip_enable_n <= 1'b1;
        tick(4);
    endtask : stop
    task automatic t_parallel();
        logic [7:0] b;
        b = pat(0);
        @(posedge clock) free_run <= 1'b1;
        enable(1'b1, 4'h2);
        tick(1);
        check_byte("first byte", b, data_pins.value);
        check_bit("scan data0 out", b[0], scan[4]);
        check_bit("scan data0 oe", 1'b0, scan[3]);
        check_bit("scan data7 out", b[7], scan[14]);
        check_bit("scan data7 oe", 1'b0, scan[13]);
        for (int i = 0; i < NBYTES; i++) begin
            get_cap(b);
            check_byte("parallel byte", pat(i), b);
        end
        tick(40);
        check_bit("cascade free run", 1'b0, cascade_n);
        check_bit("underrun", 1'b1, status.underrun);
        check_bit("overspeed", 1'b0, status.overspeed);
        stop();
    endtask : t_parallel
    task automatic t_serial();
        logic [7:0] b;
        logic [7:0] m;
        @(posedge clock);
        free_run <= 1'b0;
        pulse_limit <= 16'(TERM_COUNT);
        enable(1'b0, 4'h3);
        for (int i = 0; i < TERM_COUNT; i++) begin
            m = pat(i / 8);
            get_cap(b);
            check_bit("serial bit", m[7 - i % 8], b[0]);
        end
        tick(20);
        check_bit("cascade at limit", 1'b1, cascade_n);
        @(posedge clock) pulse_limit <= 16'(TERM_COUNT + 1);
        get_cap(b);
        tick(4);
        check_bit("cascade past limit", 1'b0, cascade_n);
        check_bit("cascade driven", 1'b0, cascade_oe_n);
        check_bit("terminal flag", 1'b1, status.passed_terminal);
        stop();
        check_bit("cascade standby", 1'b1, cascade_n);
        check_byte("oe_n standby", 8'hFF, data_pins.oe_n);
    endtask : t_serial
    task automatic t_reset_pin();
        logic [7:0] b;
        @(posedge clock) free_run <= 1'b1;
        enable(1'b1, 4'h2);
        repeat (3) get_cap(b);
        @(posedge clock) oe_drive <= 1'b0;
        tick(12);
        check_byte("oe_n held", 8'hFF, data_pins.oe_n);
        @(posedge clock) run <= 1'b0;
        @(posedge clock) oe_drive <= 1'b1;
        tick(10);
        @(posedge clock) run <= 1'b1;
        get_cap(b);
        check_byte("restart byte", pat(0), b);
        stop();
    endtask : t_reset_pin
    task automatic t_overspeed();
        enable(1'b1, 4'h1);
        tick(20);
        check_bit("overspeed", 1'b1, status.overspeed);
        stop();
    endtask : t_overspeed
    task automatic tally_and_finish();
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
    initial begin
        tick(2);
        check_bit("pin pulled in reset", 1'b0, oe_oe_n);
        check_byte("oe_n in reset", 8'hFF, data_pins.oe_n);
        @(posedge clock) reset_n <= 1'b1;
        for (int i = 0; i < NBYTES; i++) begin
            @(posedge clock);
            load_write <= 1'b1;
            load_address <= 12'(i);
            load_data <= pat(i);
        end
        @(posedge clock) load_write <= 1'b0;
        t_parallel();
        t_serial();
        t_reset_pin();
        t_overspeed();
        tally_and_finish();
    end
endmodule : tb_config_prom_readout_port
`default_nettype wire
